//--- rtl/csx_pkg.sv
// constants for the coast-stop and external-fault control block
// assumes a 200 MHz mclk; no register bus, all settings are ports
package csx_pkg;
    localparam int unsigned N_TERM = 7;
    localparam int unsigned TERM_SEL_W = 3;
    localparam logic [7:0] FAULT_CODE_NONE = 8'h00;
    localparam logic [7:0] FAULT_CODE_EXT = 8'h0C;
    localparam logic [7:0] OPT_COAST = 8'h0B;
    localparam logic [7:0] OPT_EXT_FAULT = 8'h0C;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned DEBOUNCE_NS = 50;
    localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DELAY_TICK_NS = 100;
    localparam int unsigned DELAY_TICK_CYC = (DELAY_TICK_NS * CLK_MHZ) / 1000;
    localparam int unsigned DELAY_W = 16;
    localparam int unsigned HIST_DEPTH = 4;
    typedef enum logic [2:0] {
        CSX_STOP, CSX_RUN, CSX_COAST, CSX_WAIT, CSX_TRIP
    } csx_state_e;
endpackage

//--- rtl/csx_debounce.sv
// one terminal: polarity, sync, and debounce filter
// assumes terminal levels already synchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module csx_debounce #(
    parameter int unsigned CYC = 10
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic raw,
    input wire logic active_low,
    output logic level
);
    logic s1_reg;
    logic s2_reg;
    logic [7:0] cnt_reg;

    // two-stage sample then stability count
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            cnt_reg <= 8'h00;
            level <= 1'b0;
        end else begin
            s1_reg <= raw ^ active_low;
            s2_reg <= s1_reg;
            if (s2_reg == level) begin
                cnt_reg <= 8'h00;
            end else if (cnt_reg == 8'(CYC - 1)) begin
                cnt_reg <= 8'h00;
                level <= s2_reg;
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/csx_ctrl.sv
// drive sequencing for coast stop and external fault trip
// assumes synchronous terminals, settings held stable while running
`timescale 1ns/10ps
`default_nettype none
//Contract
// - coast-stop asserted cuts drive output at once, motor coasts
// - coast-stop released with run still requested resumes drive
// - restart mode picks zero-frequency start or speed-matched start
// - restart delay holds off resumption; zero delay means no wait
// - rising external-fault edge trips, stops output, shows code 12
// - on trip motor coasts and alarm asserts immediately
// - fault input falling neither trips nor clears; trip persists
// - a clear pulse, keypad stop, reset or power cycle clears trip, returning to stopped
// - the last four trip events stay in history until reset
// - reset clears alarm and fault; run held restarts on release
// - with start guard, no self restart; needs fresh run edge or fresh clear pulse
module csx_ctrl #(
    parameter int unsigned N_TERM = csx_pkg::N_TERM
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [N_TERM-1:0] term_in,
    input wire logic [N_TERM-1:0] term_active_low,
    input wire logic [csx_pkg::TERM_SEL_W-1:0] coast_stop_sel,
    input wire logic [csx_pkg::TERM_SEL_W-1:0] ext_fault_sel,
    input wire logic run_req,
    input wire logic fault_clear_input,
    input wire logic keypad_stop,
    input wire logic restart_mode_select,
    input wire logic [csx_pkg::DELAY_W-1:0] restart_delay_time,
    input wire logic powerup_restart_guard,
    output logic drive_en,
    output logic match_speed,
    output logic coasting,
    output logic alarm_out,
    output logic [7:0] fault_code,
    output logic [7:0] fault_count,
    output logic [8*csx_pkg::HIST_DEPTH-1:0] fault_history
);
    logic [N_TERM-1:0] lvl;
    logic coast_stop_input;
    logic external_fault_input;
    logic ext_prev_reg;
    logic run_prev_reg;
    logic clr_prev_reg;
    logic ext_rise;
    logic run_rise;
    logic clear_event;
    logic guard_hold_reg;
    logic key_prev_reg;
    logic fresh_clear;
    csx_pkg::csx_state_e state_reg;
    csx_pkg::csx_state_e state_next;
    logic [csx_pkg::DELAY_W-1:0] delay_cnt_reg;
    logic [7:0] tick_reg;
    logic [7:0] hist_reg [csx_pkg::HIST_DEPTH];

    // pick a terminal's filtered level by index
    function automatic logic pick(input logic [N_TERM-1:0] v,
                                  input logic [csx_pkg::TERM_SEL_W-1:0] s);
        pick = (32'(s) < N_TERM) ? v[s] : 1'b0;
    endfunction

    // per-terminal polarity and filter
    for (genvar i = 0; i < N_TERM; i++) begin : g_term
        csx_debounce #(.CYC(csx_pkg::DEBOUNCE_CYC)) u_db (
            .mclk(mclk),
            .rst_n(rst_n),
            .raw(term_in[i]),
            .active_low(term_active_low[i]),
            .level(lvl[i])
        );
    end

    // function routing to terminals
    assign coast_stop_input = pick(lvl, coast_stop_sel);
    assign external_fault_input = pick(lvl, ext_fault_sel);
    assign ext_rise = external_fault_input & ~ext_prev_reg;
    assign run_rise = run_req & ~run_prev_reg;
    assign clear_event = (fault_clear_input & ~clr_prev_reg) | keypad_stop;
    // a fresh clear pulse outside trip also lifts the start guard
    assign fresh_clear = (fault_clear_input & ~clr_prev_reg) |
                         (keypad_stop & ~key_prev_reg);

    // edge history flops
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ext_prev_reg <= 1'b0;
            run_prev_reg <= 1'b0;
            clr_prev_reg <= 1'b0;
            key_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= external_fault_input;
            run_prev_reg <= run_req;
            clr_prev_reg <= fault_clear_input;
            key_prev_reg <= keypad_stop;
        end
    end

    // start guard: after a trip clear, wait for fresh run edge or fresh clear pulse
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            guard_hold_reg <= 1'b0;
        end else if (state_reg == csx_pkg::CSX_TRIP && clear_event) begin
            guard_hold_reg <= powerup_restart_guard;
        end else if (run_rise || !run_req || fresh_clear) begin
            guard_hold_reg <= 1'b0;
        end
    end

    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            csx_pkg::CSX_STOP: begin
                if (run_req && !guard_hold_reg && !coast_stop_input) begin
                    state_next = csx_pkg::CSX_RUN;
                end
            end
            csx_pkg::CSX_RUN: begin
                if (coast_stop_input) begin
                    state_next = csx_pkg::CSX_COAST;
                end else if (!run_req) begin
                    state_next = csx_pkg::CSX_STOP;
                end
            end
            csx_pkg::CSX_COAST: begin
                if (!coast_stop_input) begin
                    if (!run_req) begin
                        state_next = csx_pkg::CSX_STOP;
                    end else if (restart_delay_time == '0) begin
                        state_next = csx_pkg::CSX_RUN;
                    end else begin
                        state_next = csx_pkg::CSX_WAIT;
                    end
                end
            end
            csx_pkg::CSX_WAIT: begin
                if (coast_stop_input) begin
                    state_next = csx_pkg::CSX_COAST;
                end else if (!run_req) begin
                    state_next = csx_pkg::CSX_STOP;
                end else if (delay_cnt_reg == '0) begin
                    state_next = csx_pkg::CSX_RUN;
                end
            end
            csx_pkg::CSX_TRIP: begin
                if (clear_event) begin
                    state_next = csx_pkg::CSX_STOP;
                end
            end
            default: state_next = csx_pkg::CSX_STOP;
        endcase
        if (ext_rise) begin
            state_next = csx_pkg::CSX_TRIP;
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= csx_pkg::CSX_STOP;
        end else begin
            state_reg <= state_next;
        end
    end

    // restart delay count in 100 ns ticks
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            delay_cnt_reg <= '0;
            tick_reg <= 8'h00;
        end else if (state_reg != csx_pkg::CSX_WAIT) begin
            delay_cnt_reg <= restart_delay_time;
            tick_reg <= 8'h00;
        end else if (tick_reg == 8'(csx_pkg::DELAY_TICK_CYC - 1)) begin
            tick_reg <= 8'h00;
            if (delay_cnt_reg != '0) begin
                delay_cnt_reg <= delay_cnt_reg - 1'b1;
            end
        end else begin
            tick_reg <= tick_reg + 8'h01;
        end
    end

    // drive outputs follow next state so cut is immediate
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            drive_en <= 1'b0;
            coasting <= 1'b0;
            match_speed <= 1'b0;
        end else begin
            drive_en <= (state_next == csx_pkg::CSX_RUN);
            coasting <= (state_next == csx_pkg::CSX_COAST) ||
                        (state_next == csx_pkg::CSX_WAIT) ||
                        (state_next == csx_pkg::CSX_TRIP);
            if (state_next == csx_pkg::CSX_RUN && state_reg != csx_pkg::CSX_RUN) begin
                match_speed <= restart_mode_select &&
                               (state_reg != csx_pkg::CSX_STOP);
            end else if (state_next != csx_pkg::CSX_RUN) begin
                match_speed <= 1'b0;
            end
        end
    end

    // alarm and code
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            alarm_out <= 1'b0;
            fault_code <= csx_pkg::FAULT_CODE_NONE;
        end else if (ext_rise) begin
            alarm_out <= 1'b1;
            fault_code <= csx_pkg::FAULT_CODE_EXT;
        end else if (state_reg == csx_pkg::CSX_TRIP && clear_event) begin
            alarm_out <= 1'b0;
            fault_code <= csx_pkg::FAULT_CODE_NONE;
        end
    end

    // fault history: kept across trip clear, wiped only by reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fault_count <= 8'h00;
            for (int k = 0; k < csx_pkg::HIST_DEPTH; k++) begin
                hist_reg[k] <= csx_pkg::FAULT_CODE_NONE;
            end
        end else if (ext_rise) begin
            if (fault_count != 8'hFF) begin
                fault_count <= fault_count + 8'h01;
            end
            hist_reg[0] <= csx_pkg::FAULT_CODE_EXT;
            for (int k = 1; k < csx_pkg::HIST_DEPTH; k++) begin
                hist_reg[k] <= hist_reg[k-1];
            end
        end
    end

    // history flattening, newest in low byte
    always_comb begin
        for (int k = 0; k < csx_pkg::HIST_DEPTH; k++) begin
            fault_history[8*k +: 8] = hist_reg[k];
        end
    end
endmodule
`default_nettype wire

//--- tb/csx_ctrl_properties.sv
// checker for the coast stop and external trip outputs
// assumes bound to csx_ctrl, one clock domain
`timescale 1ns/10ps
`default_nettype none
module csx_ctrl_properties (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic run_req,
    input wire logic fault_clear_input,
    input wire logic keypad_stop,
    input wire logic restart_mode_select,
    input wire logic powerup_restart_guard,
    input wire logic drive_en,
    input wire logic match_speed,
    input wire logic coasting,
    input wire logic alarm_out,
    input wire logic [7:0] fault_code,
    input wire logic [8*csx_pkg::HIST_DEPTH-1:0] fault_history
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // no clear request seen for six samples
    sequence s_no_clear;
        (!fault_clear_input && !keypad_stop)[*6];
    endsequence
    // trip cleared while guard and run stay up
    sequence s_guarded_hold;
        $fell(alarm_out) ##0 (powerup_restart_guard && run_req)[*5];
    endsequence
    a_coast_cuts_drive: assert property (coasting |-> !drive_en)
        else $error("drive on while coasting");
    a_trip_code_set: assert property ($rose(alarm_out) |-> fault_code == 8'h0C)
        else $error("trip without code");
    a_trip_stops_drive: assert property (alarm_out |-> !drive_en && coasting)
        else $error("drive on during trip");
    a_trip_persists: assert property (s_no_clear ##0 $past(alarm_out) |-> alarm_out)
        else $error("trip dropped without clear");
    a_clear_ends_trip: assert property (alarm_out && $rose(fault_clear_input)
        |-> ##[1:4] (!alarm_out && fault_code == 8'h00)) else $error("clear ignored");
    a_keypad_ends_trip: assert property (alarm_out && keypad_stop |-> ##[1:4] !alarm_out)
        else $error("keypad clear ignored");
    a_history_on_trip: assert property ($changed(fault_history) |-> alarm_out)
        else $error("history changed outside trip");
    a_reset_quiet: assert property (!$past(rst_n) |-> !alarm_out && !drive_en && fault_history == '0)
        else $error("outputs live after reset");
    a_guard_no_restart: assert property (s_guarded_hold |-> !drive_en)
        else $error("restart despite guard");
    a_resume_mode: assert property ($rose(drive_en) && $past(coasting)
        |-> match_speed == restart_mode_select && $past(run_req)) else $error("resume mode wrong");
endmodule
`default_nettype wire

//--- tb/csx_contacts.sv
// model of the contacts wired to the seven input terminals
// assumes distinct terminal selections for the two functions
`timescale 1ns/10ps
`default_nettype none
module csx_contacts (
    input wire logic [2:0] coast_stop_sel,
    input wire logic [2:0] ext_fault_sel,
    input wire logic coast,
    input wire logic fault,
    input wire logic [6:0] noise,
    input wire logic [6:0] term_active_low,
    output logic [6:0] term_in
);
    // unassigned terminals chatter, assigned ones follow the contact
    always_comb begin
        term_in = noise;
        if (coast_stop_sel < 3'h7) term_in[coast_stop_sel] = coast;
        if (ext_fault_sel < 3'h7) term_in[ext_fault_sel] = fault;
        term_in = term_in ^ term_active_low;
    end
endmodule
`default_nettype wire

//--- tb/csx_ctrl_tb_top.sv
// self-checking bench for the coast stop and external trip block
// assumes the contact model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module csx_ctrl_tb_top;
    logic mclk = 0, rst_n = 0, run_req = 0, fault_clear_input = 0, keypad_stop = 0;
    logic restart_mode_select = 0, powerup_restart_guard = 0, coast = 0, fault = 0;
    logic chat = 0;
    logic [6:0] term_in, term_active_low = 7'h00;
    logic [2:0] coast_stop_sel = 3'h0, ext_fault_sel = 3'h1;
    logic [15:0] restart_delay_time = 16'h0000;
    logic drive_en, match_speed, coasting, alarm_out;
    logic [7:0] fault_code, fault_count;
    logic [31:0] fault_history, seed = 32'h0000_0027;
    int n_errors = 0, tests_run = 0;
    csx_contacts i_far (.coast_stop_sel, .ext_fault_sel, .coast, .fault, .noise({7{chat}}),
        .term_active_low, .term_in);
    csx_ctrl i_dut (.mclk, .rst_n, .term_in, .term_active_low, .coast_stop_sel, .ext_fault_sel,
        .run_req, .fault_clear_input, .keypad_stop, .restart_mode_select, .restart_delay_time,
        .powerup_restart_guard, .drive_en, .match_speed, .coasting, .alarm_out, .fault_code,
        .fault_count, .fault_history);
    // xorshift source, stepped each falling edge
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // expected history after n trips, newest in the low byte
    function automatic logic [31:0] hist(input int n);
        hist = 32'h0000_0000;
        for (int i = 0; i < n && i < 4; i++) hist = {hist[23:0], csx_pkg::FAULT_CODE_EXT};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // trip, release the contact, then clear by pulse or keypad
    task automatic trip_clear(input logic g, input logic k);
        powerup_restart_guard = g;
        fault = 1;
        cyc(20);
        chk("alarm", 1, alarm_out);
        chk("drive in trip", 0, drive_en);
        chk("code", csx_pkg::FAULT_CODE_EXT, fault_code);
        fault = 0;
        cyc(20);
        chk("alarm held", 1, alarm_out);
        if (k) keypad_stop = 1;
        else fault_clear_input = 1;
        cyc(4);
        keypad_stop = 0;
        fault_clear_input = 0;
        cyc(10);
        chk("alarm cleared", 0, alarm_out);
        chk("code cleared", 0, fault_code);
        chk("restart", !g, drive_en);
        $display("trip test guard %0d done", g);
    endtask
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    // spare terminals toggle every cycle so their filters stay low on reassignment
    always @(negedge mclk) begin
        seed <= xs(seed);
        chat <= ~chat;
    end
    initial begin
        cyc(6);
        rst_n = 1;
        chk("reset alarm", 0, alarm_out);
        run_req = 1;
        cyc(3);
        chk("start", 1, drive_en);
        chk("start speed", 0, match_speed);
        for (int m = 0; m < 4; m++) begin
            term_active_low = seed[6:0];
            coast_stop_sel = seed[9:7] % 3'h7;
            ext_fault_sel = 3'((int'(coast_stop_sel) + 1 + int'(seed[12:10]) % 6) % 7);
            restart_mode_select = m[0];
            restart_delay_time = (m < 2) ? 16'h0000 : 16'h0005;
            cyc(20);
            coast = 1;
            cyc(20);
            chk("coast drive", 0, drive_en);
            chk("coast flag", 1, coasting);
            coast = 0;
            cyc(60);
            chk("delay hold", m < 2, drive_en);
            cyc(40);
            chk("delay hold long", m < 2, drive_en);
            cyc(60);
            chk("resume", 1, drive_en);
            chk("resume speed", m[0], match_speed);
            $display("coast test %0d done", m);
        end
        trip_clear(0, 0);
        trip_clear(1, 1);
        run_req = 0;
        cyc(4);
        run_req = 1;
        cyc(4);
        chk("fresh run", 1, drive_en);
        trip_clear(1, 0);
        fault_clear_input = 1;
        cyc(2);
        fault_clear_input = 0;
        cyc(4);
        chk("pulse release", 1, drive_en);
        chk("count", 3, fault_count);
        chk("history", hist(3), fault_history);
        rst_n = 0;
        cyc(2);
        rst_n = 1;
        chk("history reset", 0, fault_history);
        $display("reset test done");
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
endmodule
bind csx_ctrl csx_ctrl_properties i_chk (.mclk, .rst_n, .run_req, .fault_clear_input, .keypad_stop,
    .restart_mode_select, .powerup_restart_guard, .drive_en, .match_speed, .coasting, .alarm_out,
    .fault_code, .fault_history);
`default_nettype wire
